// File: common/lgr_consts.svh
// Operation
// - Mode codes 000-011: independent, duplicated input, shared input, one three-input table.
// - Mode codes 100-111: multiplexer, D-latch, set/reset latch, D flip-flop.
// - Each table input has a 2-bit source: events, internal, low pins, high pins.
// - Event source maps inputs 3,2,1,0 to channels 7,1,0,6.
// - Pin sources map inputs 3,2,1,0 to pins 3,1,0,2 or 7,5,4,6.
// - Internal source: input 3 transmit line, inputs 2,0 compare 0, input 1 compare 1.
// - In 16-bit counter setup, internal input 1 takes the 16-bit waveform output.
// - Per-table bit picks strobe or asynchronous form for event-sourced inputs.
// - Only table 0 output may reach a port pin; table 1 never does.
// - Pin field: 00 off, 01 pin 0, 10 pin 4, 11 reserved.
// - Port field: 00 port C, 01 port D, 1x reserved; also picks serial unit.
// - Both table outputs appear on strobe, asynchronous and synchronous event lines.
// - Table 1 output is inserted into the selected serial transmit encoding path.
// - Table 0 output goes directly to the selected serial receive input.
// - Both byte counters' underflows share one interrupt line.
// - A separate shared line carries compare/capture interrupts of both counters.
// - Every counter interrupt condition also gives an event; glue gives events only.
// - Event-line select set takes the asynchronous line, cleared takes the strobe line.
// - Each table holds 4 truth bits indexed by its two inputs, higher input MSB.
// - Each table has a zero to two cycle delay on first input or output.
//
// Purpose: offsets, field positions, reset values and codes of the glue block
// Assumes: 32-bit register bus, one register per aligned word
// Notes: definitions only
`ifndef LGR_CONSTS_SVH
`define LGR_CONSTS_SVH

// Register indexes, byte address is four times the index
`define LGR_IDX_MODE_OUT 8'h00
`define LGR_IDX_SRC_SEL 8'h01
`define LGR_IDX_DELAY_EV 8'h02
`define LGR_IDX_TRUTH 8'h03
`define LGR_IDX_STATUS 8'h04
`define LGR_RESET_VAL 8'h00
`define LGR_MODE_RSVD_MASK 8'h08

// Mode codes
`define LGR_TWO_INDEPENDENT_TABLES 3'h0
`define LGR_TWO_TABLES_DUPLICATED_INPUT 3'h1
`define LGR_TWO_TABLES_SHARED_INPUT 3'h2
`define LGR_SINGLE_THREE_INPUT_TABLE 3'h3
`define LGR_MUX_MODE 3'h4
`define LGR_DATA_LATCH_MODE 3'h5
`define LGR_SET_RESET_LATCH_MODE 3'h6
`define LGR_FLIP_FLOP_MODE 3'h7

// Source, port, pin and delay codes
`define LGR_EVENT_NETWORK_SOURCE 2'h0
`define LGR_INTERNAL_SOURCE 2'h1
`define LGR_LOW_PINS_SOURCE 2'h2
`define LGR_HIGH_PINS_SOURCE 2'h3
`define LGR_PORT_C 2'h0
`define LGR_PORT_D 2'h1
`define LGR_PIN_OFF 2'h0
`define LGR_PIN_ZERO 2'h1
`define LGR_PIN_FOUR 2'h2
`define LGR_DLY_NONE 2'h0
`define LGR_DLY_INPUT 2'h1
`define LGR_DLY_OUTPUT 2'h2
`define LGR_PIN_ZERO_MASK 8'h01
`define LGR_PIN_FOUR_MASK 8'h10

// Bus responses
`define LGR_RESP_OKAY 2'h0
`define LGR_RESP_SLVERR 2'h2

`endif

// File: common/lgr_pkg.sv
// Purpose: shared types of the glue block
// Assumes: field layouts as in the constants header
// Notes: types only
package lgr_pkg;

	// Mode and pin output control register
	typedef struct packed {
		logic [1:0] table0_pin_output_select;
		logic [1:0] port_select;
		logic reserved;
		logic [2:0] glue_mode_select;
	} lgr_mode_out_t;

	// Delay and event line form register
	typedef struct packed {
		logic [1:0] event_line_form_select;
		logic [1:0] delay_length_select;
		logic [1:0] table1_delay_place;
		logic [1:0] table0_delay_place;
	} lgr_delay_ev_t;

	// Event network inputs
	typedef struct packed {
		logic [7:0] async_line;
		logic [7:0] strobe;
	} lgr_evt_t;

	// Byte counter interrupt conditions, one bit per counter
	typedef struct packed {
		logic [1:0] compare_capture;
		logic [1:0] underflow;
	} lgr_cnt_evt_t;

endpackage

// File: design/lgr_delay.sv
// Purpose: zero, one or two cycle delay cell
// Assumes: synchronous reset
// Notes: bypassed when not enabled
`timescale 1ns/1ps
`default_nettype none
module lgr_delay (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Control
	input wire logic enable_i,
	input wire logic two_cycles_i,
	// Data
	input wire logic d_i,
	output logic q_o
);
	import lgr_pkg::*;

	logic stage1;
	logic stage2;

	// Shift stages always run so a switch shows settled history
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= d_i;
			stage2 <= stage1;
		end
	end

	// Pick depth
	assign q_o = !enable_i ? d_i : (two_cycles_i ? stage2 : stage1);

endmodule
`default_nettype wire

// File: design/lgr_table.sv
// Purpose: one two-input lookup table
// Assumes: truth bits held by the caller
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module lgr_table (
	// Truth bits and address
	input wire logic [3:0] truth_i,
	input wire logic in_hi_i,
	input wire logic in_lo_i,
	// Table result
	output logic out_o
);
	import lgr_pkg::*;

	// Higher input is the index MSB
	assign out_o = truth_i[{in_hi_i, in_lo_i}];

endmodule
`default_nettype wire

// File: design/lgr_top.sv
// Purpose: glue logic of two lookup tables with input and output routing
// Assumes: AXI4-Lite register access, inputs synchronous to clock_i
// Notes: asynchronous event lines are combinational from the glue result, with no flop after it
//
// Local design decision: the AXI4-Lite register port.
`include "lgr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lgr_top (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Table sources
	input wire lgr_pkg::lgr_evt_t events_i,
	input wire logic [7:0] port_c_pins_i,
	input wire logic [7:0] port_d_pins_i,
	input wire logic serial_c_txd_i,
	input wire logic serial_d_txd_i,
	input wire logic compare_output_zero_i,
	input wire logic compare_output_one_i,
	input wire logic wave16_i,
	input wire logic sixteen_bit_counter_config_i,
	// Event network outputs, bit 0 table zero, bit 1 table one
	output logic [1:0] table_async_o,
	output logic [1:0] table_sync_o,
	output logic [1:0] table_strobe_o,
	// Pin outputs
	output logic pin_data_o,
	output logic [7:0] port_c_oe_o,
	output logic [7:0] port_d_oe_o,
	// Serial unit outputs
	output logic serial_d_select_o,
	output logic serial_rx_data_o,
	output logic serial_tx_insert_o,
	// Byte counter interrupts and events
	input wire lgr_pkg::lgr_cnt_evt_t counter_cond_i,
	output logic underflow_irq_o,
	output logic compare_capture_irq_o,
	output lgr_pkg::lgr_cnt_evt_t counter_event_o
);
	import lgr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////////
	// Registers and bus slave

	lgr_mode_out_t mode_out;
	logic [7:0] src_sel;
	lgr_delay_ev_t delay_ev;
	logic [7:0] truth;
	logic aw_held;
	logic [7:0] aw_addr;
	logic w_held;
	logic [7:0] w_data;
	logic w_lane0;
	logic wr_fire;
	logic wr_hit;
	logic [7:0] status;

	// Word index of a byte address, misaligned gives an impossible index
	function automatic logic [7:0] word_index(input logic [7:0] addr);
		word_index = (addr[1:0] == 2'h0) ? {2'h0, addr[7:2]} : 8'hff;
	endfunction

	// Address and data held apart so they may arrive in either order
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
	assign wr_fire = aw_held && w_held;

	// Address channel
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	// Data channel, only the low byte lane carries register bits
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i[7:0];
			w_lane0 <= s_axi_wstrb_i[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		case (word_index(aw_addr))
			`LGR_IDX_MODE_OUT, `LGR_IDX_SRC_SEL, `LGR_IDX_DELAY_EV, `LGR_IDX_TRUTH,
			`LGR_IDX_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Register update, effective from the next cycle as a whole byte
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mode_out <= lgr_mode_out_t'(`LGR_RESET_VAL);
			src_sel <= `LGR_RESET_VAL;
			delay_ev <= lgr_delay_ev_t'(`LGR_RESET_VAL);
			truth <= `LGR_RESET_VAL;
		end else if (wr_fire && w_lane0) begin
			case (word_index(aw_addr))
				`LGR_IDX_MODE_OUT: mode_out <= lgr_mode_out_t'(w_data & ~`LGR_MODE_RSVD_MASK);
				`LGR_IDX_SRC_SEL: src_sel <= w_data;
				`LGR_IDX_DELAY_EV: delay_ev <= lgr_delay_ev_t'(w_data);
				`LGR_IDX_TRUTH: truth <= w_data;
				default: ;
			endcase
		end
	end

	// Write response, unmapped addresses answer with an error
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `LGR_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_hit ? `LGR_RESP_OKAY : `LGR_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// Read path, one word at a time
	assign s_axi_arready_o = !s_axi_rvalid_o;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= `LGR_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `LGR_RESP_OKAY;
			case (word_index(s_axi_araddr_i))
				`LGR_IDX_MODE_OUT: s_axi_rdata_o <= {24'h0, mode_out};
				`LGR_IDX_SRC_SEL: s_axi_rdata_o <= {24'h0, src_sel};
				`LGR_IDX_DELAY_EV: s_axi_rdata_o <= {24'h0, delay_ev};
				`LGR_IDX_TRUTH: s_axi_rdata_o <= {24'h0, truth};
				`LGR_IDX_STATUS: s_axi_rdata_o <= {24'h0, status};
				default: begin
					s_axi_rdata_o <= 32'h0;
					s_axi_rresp_o <= `LGR_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Input routing

	logic [7:0] pins;
	logic [7:0] ev_t0;
	logic [7:0] ev_t1;
	logic port_ok;
	logic txd_sel;
	logic int_in1;
	logic [3:0] in_raw;

	// Choose one source for a table input
	function automatic logic pick(input logic [1:0] sel, input logic ev, input logic int_sig,
		input logic low, input logic high);
		case (sel)
			`LGR_EVENT_NETWORK_SOURCE: pick = ev;
			`LGR_INTERNAL_SOURCE: pick = int_sig;
			`LGR_LOW_PINS_SOURCE: pick = low;
			default: pick = high;
		endcase
	endfunction

	// Reserved port codes route no pins at all
	always_comb begin
		port_ok = 1'b1;
		case (mode_out.port_select)
			`LGR_PORT_C: pins = port_c_pins_i;
			`LGR_PORT_D: pins = port_d_pins_i;
			default: begin
				pins = 8'h00;
				port_ok = 1'b0;
			end
		endcase
	end

	// Event line form per table
	assign ev_t0 = delay_ev.event_line_form_select[0] ? events_i.async_line : events_i.strobe;
	assign ev_t1 = delay_ev.event_line_form_select[1] ? events_i.async_line : events_i.strobe;
	assign txd_sel = (mode_out.port_select == `LGR_PORT_D) ? serial_d_txd_i : serial_c_txd_i;
	assign int_in1 = sixteen_bit_counter_config_i ? wave16_i : compare_output_one_i;

	// Fixed channel and pin maps per input
	assign in_raw[3] = pick(src_sel[7:6], ev_t1[7], txd_sel, pins[3], pins[7]);
	assign in_raw[2] = pick(src_sel[5:4], ev_t1[1], compare_output_zero_i, pins[1], pins[5]);
	assign in_raw[1] = pick(src_sel[3:2], ev_t0[0], int_in1, pins[0], pins[4]);
	assign in_raw[0] = pick(src_sel[1:0], ev_t0[6], compare_output_zero_i, pins[2], pins[6]);

	////////////////////////////////////////////////////////////////////////////////////
	// Tables, delays and modes

	logic d_in0;
	logic d_in2;
	logic a0_hi;
	logic a0_lo;
	logic a1_hi;
	logic a1_lo;
	logic t0;
	logic t1;
	logic y0;
	logic y1;
	logic seq_q;
	logic [1:0] glue_out;

	// First input of each table may carry the delay
	lgr_delay u_dly_in0 (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(delay_ev.table0_delay_place == `LGR_DLY_INPUT),
		.two_cycles_i(delay_ev.delay_length_select[0]),
		.d_i(in_raw[0]),
		.q_o(d_in0)
	);
	lgr_delay u_dly_in2 (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(delay_ev.table1_delay_place == `LGR_DLY_INPUT),
		.two_cycles_i(delay_ev.delay_length_select[1]),
		.d_i(in_raw[2]),
		.q_o(d_in2)
	);

	// Table one never reads table zero, so the cascade has no loop
	always_comb begin
		a1_hi = in_raw[3];
		a1_lo = d_in2;
		a0_hi = in_raw[1];
		a0_lo = d_in0;
		case (mode_out.glue_mode_select)
			`LGR_TWO_TABLES_DUPLICATED_INPUT: begin
				a0_hi = d_in0;
				a1_hi = d_in2;
			end
			`LGR_TWO_TABLES_SHARED_INPUT: a1_lo = d_in0;
			`LGR_SINGLE_THREE_INPUT_TABLE: begin
				a0_hi = d_in0;
				a0_lo = y1;
			end
			default: ;
		endcase
	end

	lgr_table u_table_zero (
		.truth_i(truth[3:0]),
		.in_hi_i(a0_hi),
		.in_lo_i(a0_lo),
		.out_o(t0)
	);
	lgr_table u_table_one (
		.truth_i(truth[7:4]),
		.in_hi_i(a1_hi),
		.in_lo_i(a1_lo),
		.out_o(t1)
	);

	// Output delay cells
	lgr_delay u_dly_out0 (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(delay_ev.table0_delay_place == `LGR_DLY_OUTPUT),
		.two_cycles_i(delay_ev.delay_length_select[0]),
		.d_i(t0),
		.q_o(y0)
	);
	lgr_delay u_dly_out1 (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(delay_ev.table1_delay_place == `LGR_DLY_OUTPUT),
		.two_cycles_i(delay_ev.delay_length_select[1]),
		.d_i(t1),
		.q_o(y1)
	);

	// Storage element, held at zero in purely combinational modes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			seq_q <= 1'b0;
		end else begin
			case (mode_out.glue_mode_select)
				`LGR_DATA_LATCH_MODE: seq_q <= y1 ? y0 : seq_q;
				`LGR_SET_RESET_LATCH_MODE: seq_q <= y0 ? 1'b1 : (y1 ? 1'b0 : seq_q);
				`LGR_FLIP_FLOP_MODE: seq_q <= y1 ? y0 : seq_q;
				default: seq_q <= 1'b0;
			endcase
		end
	end

	// Final table zero result per mode, latches are transparent while open
	always_comb begin
		glue_out = {y1, y0};
		case (mode_out.glue_mode_select)
			`LGR_MUX_MODE: glue_out[0] = y1 ? in_raw[1] : in_raw[0];
			`LGR_DATA_LATCH_MODE: glue_out[0] = y1 ? y0 : seq_q;
			`LGR_SET_RESET_LATCH_MODE: glue_out[0] = y0 ? 1'b1 : (y1 ? 1'b0 : seq_q);
			`LGR_FLIP_FLOP_MODE: glue_out[0] = seq_q;
			default: ;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Output routing

	// Asynchronous line follows the logic directly, no flop in the path
	assign table_async_o = glue_out;

	// Synchronous level and one-cycle strobe on each rising edge
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			table_sync_o <= 2'h0;
			table_strobe_o <= 2'h0;
		end else begin
			table_sync_o <= glue_out;
			table_strobe_o <= glue_out & ~table_sync_o;
		end
	end

	// Pin drive, table zero only; reserved codes leave the pins undriven
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pin_data_o <= 1'b0;
			port_c_oe_o <= 8'h00;
			port_d_oe_o <= 8'h00;
		end else begin
			pin_data_o <= glue_out[0];
			port_c_oe_o <= 8'h00;
			port_d_oe_o <= 8'h00;
			if (port_ok && mode_out.table0_pin_output_select == `LGR_PIN_ZERO) begin
				if (mode_out.port_select == `LGR_PORT_D) port_d_oe_o <= `LGR_PIN_ZERO_MASK;
				else port_c_oe_o <= `LGR_PIN_ZERO_MASK;
			end else if (port_ok && mode_out.table0_pin_output_select == `LGR_PIN_FOUR) begin
				if (mode_out.port_select == `LGR_PORT_D) port_d_oe_o <= `LGR_PIN_FOUR_MASK;
				else port_c_oe_o <= `LGR_PIN_FOUR_MASK;
			end
		end
	end

	// Serial unit links
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			serial_d_select_o <= 1'b0;
			serial_rx_data_o <= 1'b0;
			serial_tx_insert_o <= 1'b0;
		end else begin
			serial_d_select_o <= (mode_out.port_select == `LGR_PORT_D);
			serial_rx_data_o <= glue_out[0];
			serial_tx_insert_o <= glue_out[1];
		end
	end

	// Counter conditions: shared interrupt lines, one event each; glue adds none
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			underflow_irq_o <= 1'b0;
			compare_capture_irq_o <= 1'b0;
			counter_event_o <= lgr_cnt_evt_t'(4'h0);
		end else begin
			underflow_irq_o <= |counter_cond_i.underflow;
			compare_capture_irq_o <= |counter_cond_i.compare_capture;
			counter_event_o <= counter_cond_i;
		end
	end

	// Status word shows live logic state
	assign status = {5'h0, seq_q, glue_out};

endmodule
`default_nettype wire

// File: verif/lgr_far_model.sv
// Purpose: port pins at the far side of the glue block
// Assumes: an undriven pin shows the level asked for by the bench
// Notes: a driven pin reads back the block's own level
`timescale 1ns/1ps
`default_nettype none
module lgr_far_model (
	// External pin levels
	input wire logic [7:0] pc_i,
	input wire logic [7:0] pd_i,
	// Drive from the block
	input wire logic pin_data_i,
	input wire logic [7:0] c_oe_i,
	input wire logic [7:0] d_oe_i,
	// Pin levels seen by the block
	output logic [7:0] pc_o,
	output logic [7:0] pd_o
);
	// Resolve each wire from both parties
	assign pc_o = (pc_i & ~c_oe_i) | ({8{pin_data_i}} & c_oe_i);
	assign pd_o = (pd_i & ~d_oe_i) | ({8{pin_data_i}} & d_oe_i);
endmodule
`default_nettype wire

// File: verif/lgr_top_sva.sv
// Purpose: concurrent checks on the glue block outputs
// Assumes: one clock, synchronous active-high reset
// Notes: watches only ports of the top module
`timescale 1ns/1ps
`default_nettype none
module lgr_top_sva (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Glue outputs
	input wire logic [1:0] table_async_o,
	input wire logic [1:0] table_sync_o,
	input wire logic [1:0] table_strobe_o,
	input wire logic [7:0] port_c_oe_o,
	input wire logic [7:0] port_d_oe_o,
	input wire logic serial_rx_data_o,
	input wire logic serial_tx_insert_o,
	// Counter group
	input wire lgr_pkg::lgr_cnt_evt_t counter_cond_i,
	input wire logic underflow_irq_o,
	input wire logic compare_capture_irq_o,
	input wire lgr_pkg::lgr_cnt_evt_t counter_event_o
);
	import lgr_pkg::*;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// Table zero rising on the synchronous line
	sequence sync0_rise;
		!table_sync_o[0] ##1 table_sync_o[0];
	endsequence
	// Strobe is one cycle wide, never a level
	property strobe_pulse;
		sync0_rise |-> table_strobe_o[0] ##1 !table_strobe_o[0];
	endproperty
	////////////////////////////////////////////////////////////////
	sync_trails_a: assert property (table_sync_o == $past(table_async_o))
		else $error("sync line does not trail async line");
	strobe_form_a: assert property (table_strobe_o == (table_sync_o & ~$past(table_sync_o)))
		else $error("strobe line not on a rising sync edge");
	strobe_width_a: assert property (strobe_pulse)
		else $error("strobe pulse wider than one cycle");
	rx_direct_a: assert property (serial_rx_data_o == $past(table_async_o[0]))
		else $error("receive line does not carry table zero");
	tx_insert_a: assert property (serial_tx_insert_o == $past(table_async_o[1]))
		else $error("transmit insert does not carry table one");
	pin_place_a: assert property (((port_c_oe_o | port_d_oe_o) & 8'hee) == 8'h00 && !(|port_c_oe_o && |port_d_oe_o))
		else $error("pin drive outside pin 0 or 4 of one port");
	uf_irq_a: assert property (underflow_irq_o == |$past(counter_cond_i.underflow))
		else $error("shared underflow line wrong");
	cc_irq_a: assert property (compare_capture_irq_o == |$past(counter_cond_i.compare_capture))
		else $error("shared compare line missed a condition");
	evt_copy_a: assert property (counter_event_o == $past(counter_cond_i))
		else $error("counter event does not follow its condition");
endmodule
bind lgr_top lgr_top_sva u_lgr_top_sva (
	.clock_i(clock_i), .rst_i(rst_i), .table_async_o(table_async_o),
	.table_sync_o(table_sync_o), .table_strobe_o(table_strobe_o),
	.port_c_oe_o(port_c_oe_o), .port_d_oe_o(port_d_oe_o),
	.serial_rx_data_o(serial_rx_data_o), .serial_tx_insert_o(serial_tx_insert_o),
	.counter_cond_i(counter_cond_i), .underflow_irq_o(underflow_irq_o),
	.compare_capture_irq_o(compare_capture_irq_o), .counter_event_o(counter_event_o)
);
`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench of the glue block
// Assumes: one bus access at a time, fixed seed
// Notes: storage modes are judged once the inputs have settled
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lgr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	lgr_evt_t ev = 16'h0000;
	lgr_cnt_evt_t cnt = 4'h0;
	logic [7:0] pc = 8'h00, pd = 8'h00, mo = 8'h00, src = 8'h00, dl = 8'h00, tr = 8'h00, oe;
	logic [5:0] misc = 6'h00;
	logic q_ref = 1'b0;
	logic [1:0] rsp, bresp, rresp, async;
	logic [31:0] rd, rdata;
	logic awready, wready, bvalid, arready, rvalid, pin_data, dsel;
	logic [7:0] c_oe, d_oe, pcm, pdm;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	////////////////////////////////////////////////////////////////
	lgr_top u_lgr_top (.clock_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .events_i(ev), .port_c_pins_i(pcm), .port_d_pins_i(pdm),
		.serial_c_txd_i(misc[0]), .serial_d_txd_i(misc[1]), .compare_output_zero_i(misc[2]),
		.compare_output_one_i(misc[3]), .wave16_i(misc[4]),
		.sixteen_bit_counter_config_i(misc[5]), .table_async_o(async), .table_sync_o(),
		.table_strobe_o(), .pin_data_o(pin_data), .port_c_oe_o(c_oe), .port_d_oe_o(d_oe),
		.serial_d_select_o(dsel), .serial_rx_data_o(), .serial_tx_insert_o(),
		.counter_cond_i(cnt), .underflow_irq_o(), .compare_capture_irq_o(),
		.counter_event_o());
	lgr_far_model u_lgr_far_model (.pc_i(pc), .pd_i(pd), .pin_data_i(pin_data),
		.c_oe_i(c_oe), .d_oe_i(d_oe), .pc_o(pcm), .pd_o(pdm));
	////////////////////////////////////////////////////////////////
	// Clock, and a ceiling well above the planned run
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("Error %0t run did not finish", $time);
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Bus words and glue outputs are compared apart
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t bus got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t output got %h want %h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	// Mode goes to zero first so storage starts from a known state
	task automatic set_cfg();
		q_ref = 1'b0;
		axi_wr(8'h00, 8'h00, rsp);
		axi_wr(8'h0c, tr, rsp);
		axi_wr(8'h04, src, rsp);
		axi_wr(8'h08, dl, rsp);
		axi_wr(8'h00, mo, rsp);
	endtask
	// Reference of routing, tables and storage
	task automatic judge(input logic cmp);
		int ec[4] = '{6, 0, 1, 7};
		int pl[4] = '{2, 0, 1, 3};
		logic [7:0] pins;
		logic [3:0] v;
		logic t0, t1, o0;
		pins = (mo[5:4] == 2'h0) ? pc : (mo[5:4] == 2'h1) ? pd : 8'h00;
		for (int i = 0; i < 4; i++) begin
			case (src[2*i +: 2])
				2'h0: v[i] = dl[6 + i/2] ? ev.async_line[ec[i]] : ev.strobe[ec[i]];
				2'h1: v[i] = (i == 3) ? misc[mo[5:4] == 2'h1] : (i == 1) ? (misc[5] ? misc[4] : misc[3]) : misc[2];
				2'h2: v[i] = pins[pl[i]];
				default: v[i] = pins[pl[i] + 4];
			endcase
		end
		t0 = tr[{v[1], v[0]}];
		t1 = tr[4 + {v[3], v[2]}];
		case (mo[2:0])
			3'h1: begin
				t0 = tr[{v[0], v[0]}];
				t1 = tr[4 + {v[2], v[2]}];
			end
			3'h2: t1 = tr[4 + {v[3], v[0]}];
			3'h3: t0 = tr[{v[0], t1}];
			default: ;
		endcase
		o0 = (mo[2:0] == 3'h4) ? (t1 ? v[1] : v[0]) : t0;
		case (mo[2:0])
			3'h5, 3'h7: q_ref = t1 ? t0 : q_ref;
			3'h6: q_ref = t0 ? 1'b1 : (t1 ? 1'b0 : q_ref);
			default: q_ref = 1'b0;
		endcase
		if (cmp && mo[2:0] > 3'h4) begin
			chk_out({7'h00, async[0]}, {7'h00, q_ref});
		end else if (cmp) begin
			chk_out({6'h00, async}, {6'h00, t1, o0});
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(94));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values, an unmapped place, a mode write with the reserved bit left clear
		for (int a = 0; a < 16; a += 4) begin
			axi_rd(8'(a), rd, rsp);
			chk_val(rd, 32'h0);
		end
		axi_rd(8'h40, rd, rsp);
		chk_val({30'h0, rsp}, 32'h2);
		axi_wr(8'h40, 8'h55, rsp);
		chk_val({30'h0, rsp}, 32'h2);
		axi_wr(8'h00, 8'hf7, rsp);
		axi_rd(8'h00, rd, rsp);
		chk_val(rd, 32'hf7);
		$display("test registers done");
		// Every pin code against every port code
		axi_wr(8'h0c, 8'h0f, rsp);
		for (int p = 0; p < 16; p++) begin
			axi_wr(8'h00, {p[1:0], p[3:2], 4'h0}, rsp);
			oe = (p[1:0] == 2'h1) ? 8'h01 : (p[1:0] == 2'h2) ? 8'h10 : 8'h00;
			chk_out(c_oe, (p[3:2] == 2'h0) ? oe : 8'h00);
			chk_out(d_oe, (p[3:2] == 2'h1) ? oe : 8'h00);
			chk_out({7'h00, dsel}, {7'h00, p[3:2] == 2'h1});
			chk_out({7'h00, pin_data}, 8'h01);
		end
		$display("test pins done");
		// Random routing, every mode in turn; pin drive kept off to avoid readback
		for (int k = 0; k < 150; k++) begin
			tr = 8'($urandom);
			src = 8'($urandom);
			dl = {2'($urandom), 2'($urandom), ((k[2:0] > 3'h4) ? 4'h0 : 4'($urandom))};
			mo = {($urandom_range(0, 1) == 1) ? 2'h3 : 2'h0, 2'($urandom), 1'b0, k[2:0]};
			if (mo[2:0] == 3'h2) dl[7] = dl[6];
			set_cfg();
			judge(1'b0);
			ev <= 16'($urandom);
			pc <= 8'($urandom);
			pd <= 8'($urandom);
			misc <= 6'($urandom);
			cnt <= 4'($urandom);
			@(posedge clk);
			cnt <= 4'h0;
			@(posedge clk);
			repeat (3) @(posedge clk);
			judge(1'b1);
		end
		$display("test routing done");
		// Two-cycle output delay on table zero, pin 2 passed straight through
		pc <= 8'h00;
		tr = 8'h0a;
		src = 8'h02;
		dl = 8'h12;
		mo = 8'h00;
		set_cfg();
		pc <= 8'h04;
		repeat (2) begin
			@(posedge clk);
			chk_out({7'h00, async[0]}, 8'h00);
		end
		@(posedge clk);
		chk_out({7'h00, async[0]}, 8'h01);
		$display("test delay done");
		wrap_up();
	end
endmodule
`default_nettype wire
